// ==== logic/stc_pkg.sv ====
package stc_pkg;

  // Register port geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 16;
  localparam int PS_W   = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CNT_LO   = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CNT_HI   = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_FLAG     = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_PIN_DIR  = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_PIN_DATA = 3'h5;

  // Control field positions
  localparam int CTRL_ON_BIT    = 0;
  localparam int CTRL_CS_BIT    = 1;
  localparam int CTRL_ASYNC_BIT = 2;
  localparam int CTRL_OSC_BIT   = 3;
  localparam int CTRL_PS_LSB    = 4;
  localparam int CTRL_PS_MSB    = 5;
  localparam int CTRL_USED_W    = 6;
  localparam int FLAG_OVF_BIT   = 0;

  // Values after reset
  localparam logic [CTRL_USED_W-1:0] CTRL_RESET     = 6'h00;
  localparam logic [CNT_W-1:0]       CNT_RESET      = 16'h0000;
  localparam logic [CNT_W-1:0]       CNT_MAX        = 16'hffff;
  localparam logic [1:0]             PIN_DIR_RESET  = 2'h3;
  localparam logic [1:0]             PIN_DATA_RESET = 2'h0;

  // Instruction clock is the system clock divided by four
  localparam int         INSTR_DIV  = 4;
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

  // Falling-edge arming of the external count input
  typedef enum logic [1:0] {
    ARM_WAIT_FALL = 2'b01,
    ARM_READY     = 2'b10
  } stc_arm_e;

endpackage

// ==== logic/stc_prescale.sv ====
`timescale 1ns/1ps
`default_nettype none
module stc_prescale #(
  parameter int PS_W = 3
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clr,
  input  wire logic       step,
  input  wire logic [1:0] sel,
  output logic            fire
);
  import stc_pkg::*;

  logic [PS_W-1:0] ps_q;
  logic [PS_W-1:0] ps_d;
  logic [PS_W-1:0] mask;

  // Low sel bits must all be ones; wrap of the counter keeps the period exact
  always_comb begin
    mask = PS_W'((4'h1 << sel) - 4'h1);
    fire = step && ((ps_q & mask) == mask);
    ps_d = ps_q;
    if (clr) begin
      ps_d = '0;
    end else if (step) begin
      ps_d = ps_q + PS_W'(1);
    end
  end

  // Counter itself has no register address; software clears it only by writing a count byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ps_q <= '0;
    end else begin
      ps_q <= ps_d;
    end
  end

endmodule
`default_nettype wire

// ==== logic/stc_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module stc_timer (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [stc_pkg::ADDR_W-1:0] addr,
  input  wire logic [stc_pkg::DATA_W-1:0] wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic      [stc_pkg::DATA_W-1:0] rdata,
  input  wire logic                      sleep,
  input  wire logic                      primary_clk_ok,
  input  wire logic                      pin_a_in,
  input  wire logic                      pin_b_in,
  output logic                           pin_a_out,
  output logic                           pin_a_oe,
  output logic                           pin_b_out,
  output logic                           pin_b_oe,
  output logic                           osc_run,
  output logic      [stc_pkg::CNT_W-1:0]  count_value,
  output logic                           time_base_valid,
  output logic                           overflow_flag,
  output logic                           wake
);
  import stc_pkg::*;

  // Software state
  logic [CTRL_USED_W-1:0] ctrl_q;
  logic [CTRL_USED_W-1:0] ctrl_d;
  logic [1:0]             dir_q;
  logic [1:0]             dir_d;
  logic [1:0]             data_q;
  logic [1:0]             data_d;
  logic [DATA_W-1:0]      rdata_q;
  logic [DATA_W-1:0]      rdata_d;
  logic                   osc_q;
  logic                   osc_d;
  logic                   pa_out_q;
  logic                   pa_oe_q;
  logic                   pb_out_q;
  logic                   pb_oe_q;
  logic                   pa_out_d;
  logic                   pa_oe_d;
  logic                   pb_out_d;
  logic                   pb_oe_d;
  logic                   tbv_q;
  logic                   tbv_d;

  // Counting state
  logic [1:0]             qcnt_q;
  logic [1:0]             qcnt_d;
  logic                   sync1_q;
  logic                   sync2_q;
  logic                   sync_prev_q;
  logic                   raw_q;
  logic                   raw_prev_q;
  logic                   sync1_d;
  logic                   sync2_d;
  logic                   sync_prev_d;
  logic                   raw_d;
  logic                   raw_prev_d;
  stc_arm_e               arm_q;
  stc_arm_e               arm_d;
  logic [CNT_W-1:0]       cnt_q;
  logic [CNT_W-1:0]       cnt_d;
  logic                   flag_q;
  logic                   flag_d;
  logic                   wake_q;
  logic                   wake_d;

  // Decoded controls and events
  logic       tmr_on;
  logic       src_ext;
  logic       async_mode;
  logic [1:0] ps_sel;
  logic       wr_lo;
  logic       wr_hi;
  logic       wr_cnt;
  logic       ext_src;
  logic       sel_lvl;
  logic       sel_prev;
  logic       ext_rise;
  logic       ext_fall;
  logic       instr_tick;
  logic       step;
  logic       fire;
  logic       ovf;
  logic [1:0] dir_eff;

  // Field views of the control register
  assign tmr_on     = ctrl_q[CTRL_ON_BIT];
  assign src_ext    = ctrl_q[CTRL_CS_BIT];
  assign async_mode = src_ext && ctrl_q[CTRL_ASYNC_BIT];
  assign ps_sel     = ctrl_q[CTRL_PS_MSB:CTRL_PS_LSB];
  assign wr_lo      = wr && (addr == ADDR_CNT_LO);
  assign wr_hi      = wr && (addr == ADDR_CNT_HI);
  assign wr_cnt     = wr_lo || wr_hi;

  // Oscillator pin replaces the count pin only while it may run
  assign ext_src = osc_q ? pin_b_in : pin_a_in;

  // Async path sees one sample less of delay, so a mode switch can slip a count
  assign sel_lvl  = async_mode ? raw_q : sync2_q;
  assign sel_prev = async_mode ? raw_prev_q : sync_prev_q;
  assign ext_rise = sel_lvl && !sel_prev;
  assign ext_fall = !sel_lvl && sel_prev;

  // Instruction clock halts in sleep with the core
  assign instr_tick = (qcnt_q == INSTR_LAST) && !sleep;

  // One prescaler input step per selected clock event
  always_comb begin
    step = 1'b0;
    if (tmr_on) begin
      if (!src_ext) begin
        step = instr_tick;
      end else if (arm_q == ARM_READY) begin
        step = ext_rise && (async_mode || !sleep);
      end
    end
  end

  stc_prescale #(
    .PS_W (PS_W)
  ) u_prescale (
    .clk  (clk),
    .rst  (rst),
    .clr  (wr_cnt),
    .step (step),
    .sel  (ps_sel),
    .fire (fire)
  );

  assign ovf = fire && !wr_cnt && (cnt_q == CNT_MAX);

  // Pins read as inputs while the oscillator owns them
  assign dir_eff = osc_q ? 2'b11 : dir_q;

  // Register writes, read answer and pin drive
  always_comb begin
    ctrl_d  = ctrl_q;
    dir_d   = dir_q;
    data_d  = data_q;
    rdata_d = '0;
    if (wr) begin
      if (addr == ADDR_CTRL) begin
        ctrl_d = wdata[CTRL_USED_W-1:0];
      end else if (addr == ADDR_PIN_DIR) begin
        dir_d = wdata[1:0];
      end else if (addr == ADDR_PIN_DATA) begin
        data_d = wdata[1:0];
      end
    end
    if (rd) begin
      if (addr == ADDR_CTRL) begin
        rdata_d = {2'h0, ctrl_q};
      end else if (addr == ADDR_CNT_LO) begin
        rdata_d = cnt_q[7:0];
      end else if (addr == ADDR_CNT_HI) begin
        rdata_d = cnt_q[15:8];
      end else if (addr == ADDR_FLAG) begin
        rdata_d = {7'h00, flag_q};
      end else if (addr == ADDR_PIN_DIR) begin
        rdata_d = {6'h00, dir_eff};
      end else if (addr == ADDR_PIN_DATA) begin
        rdata_d = osc_q ? 8'h00 : {6'h00, pin_b_in, pin_a_in};
      end else begin
        rdata_d = 8'h00;
      end
    end
    // Enable is independent of sleep, so the crystal keeps ticking
    osc_d    = ctrl_d[CTRL_OSC_BIT] && primary_clk_ok;
    pa_out_d = data_d[0];
    pb_out_d = data_d[1];
    pa_oe_d  = !(osc_d || dir_d[0]);
    pb_oe_d  = !(osc_d || dir_d[1]);
    tbv_d    = ctrl_d[CTRL_ON_BIT] &&
               !(ctrl_d[CTRL_CS_BIT] && ctrl_d[CTRL_ASYNC_BIT]);
  end

  // Software-facing flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q   <= CTRL_RESET;
      dir_q    <= PIN_DIR_RESET;
      data_q   <= PIN_DATA_RESET;
      rdata_q  <= '0;
      osc_q    <= 1'b0;
      pa_out_q <= 1'b0;
      pb_out_q <= 1'b0;
      pa_oe_q  <= 1'b0;
      pb_oe_q  <= 1'b0;
      tbv_q    <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      dir_q    <= dir_d;
      data_q   <= data_d;
      rdata_q  <= rdata_d;
      osc_q    <= osc_d;
      pa_out_q <= pa_out_d;
      pb_out_q <= pb_out_d;
      pa_oe_q  <= pa_oe_d;
      pb_oe_q  <= pb_oe_d;
      tbv_q    <= tbv_d;
    end
  end

  // Sampling, arming, count and flag next values
  always_comb begin
    qcnt_d      = qcnt_q + 2'h1;
    sync1_d     = ext_src;
    sync2_d     = sync1_q;
    sync_prev_d = sync2_q;
    raw_d       = ext_src;
    raw_prev_d  = raw_q;
    arm_d       = arm_q;
    case (arm_q)
      ARM_WAIT_FALL: begin
        if (tmr_on && ext_fall && !wr_cnt) begin
          arm_d = ARM_READY;
        end
      end
      ARM_READY: begin
        // Stopping with the input high forgets the seen falling edge
        if (wr_cnt || (!tmr_on && sel_lvl)) begin
          arm_d = ARM_WAIT_FALL;
        end
      end
      default: begin
        arm_d = ARM_WAIT_FALL;
      end
    endcase
    cnt_d = cnt_q;
    if (wr_cnt) begin
      if (wr_lo) begin
        cnt_d[7:0] = wdata;
      end
      if (wr_hi) begin
        cnt_d[15:8] = wdata;
      end
    end else if (fire) begin
      cnt_d = cnt_q + CNT_W'(1);
    end
    // Hardware set beats a same-cycle software clear
    flag_d = flag_q;
    if (wr && (addr == ADDR_FLAG)) begin
      flag_d = wdata[FLAG_OVF_BIT];
    end
    if (ovf) begin
      flag_d = 1'b1;
    end
    wake_d = ovf && sleep;
  end

  // Counting flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qcnt_q      <= 2'h0;
      sync1_q     <= 1'b0;
      sync2_q     <= 1'b0;
      sync_prev_q <= 1'b0;
      raw_q       <= 1'b0;
      raw_prev_q  <= 1'b0;
      arm_q       <= ARM_WAIT_FALL;
      cnt_q       <= CNT_RESET;
      flag_q      <= 1'b0;
      wake_q      <= 1'b0;
    end else begin
      qcnt_q      <= qcnt_d;
      sync1_q     <= sync1_d;
      sync2_q     <= sync2_d;
      sync_prev_q <= sync_prev_d;
      raw_q       <= raw_d;
      raw_prev_q  <= raw_prev_d;
      arm_q       <= arm_d;
      cnt_q       <= cnt_d;
      flag_q      <= flag_d;
      wake_q      <= wake_d;
    end
  end

  // Outputs straight from flops
  assign rdata           = rdata_q;
  assign pin_a_out       = pa_out_q;
  assign pin_a_oe        = pa_oe_q;
  assign pin_b_out       = pb_out_q;
  assign pin_b_oe        = pb_oe_q;
  assign osc_run         = osc_q;
  assign count_value     = cnt_q;
  assign time_base_valid = tbv_q;
  assign overflow_flag   = flag_q;
  assign wake            = wake_q;

endmodule
`default_nettype wire

// ==== verif/stc_ext_src.sv ====
`timescale 1ns/1ps
`default_nettype none
module stc_ext_src (
  input  wire logic osc_run,
  output logic      pin_a,
  output logic      pin_b
);
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // Crystal swings only while enabled, otherwise stands still
  always begin
    #15259 pin_b = osc_run ? ~pin_b : 1'b0;
  end
  // Each pulse ends low, so the next burst starts with a rise
  task automatic pulses(input int n);
    repeat (n) begin
      #537 pin_a = 1'b1;
      #537 pin_a = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== verif/stc_timer_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module stc_timer_checker (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic [stc_pkg::ADDR_W-1:0] addr,
  input wire logic [stc_pkg::DATA_W-1:0] wdata,
  input wire logic                       wr,
  input wire logic                       rd,
  input wire logic [stc_pkg::DATA_W-1:0] rdata,
  input wire logic                       sleep,
  input wire logic                       primary_clk_ok,
  input wire logic                       pin_a_oe,
  input wire logic                       pin_b_oe,
  input wire logic                       osc_run,
  input wire logic [stc_pkg::CNT_W-1:0]  count_value,
  input wire logic                       overflow_flag,
  input wire logic                       wake
);
  import stc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Count bytes through the register port
  property p_rd_hi;
    rd && addr == ADDR_CNT_HI |=> rdata == $past(count_value[15:8]);
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("high byte read wrong");
  property p_wr_lo;
    wr && addr == ADDR_CNT_LO |=> count_value[7:0] == $past(wdata);
  endproperty
  a_wr_lo: assert property (p_wr_lo) else $error("low byte write lost");
  property p_wr_hi;
    wr && addr == ADDR_CNT_HI |=> count_value[15:8] == $past(wdata);
  endproperty
  a_wr_hi: assert property (p_wr_hi) else $error("high byte write lost");
  // Without a write the count holds or moves up by one
  property p_step;
    !wr |=> $stable(count_value) || count_value == $past(count_value) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("count jumped");
  property p_ovf;
    count_value == 16'hffff && !wr ##1 count_value == 16'h0000 |-> ##[0:1] overflow_flag;
  endproperty
  a_ovf: assert property (p_ovf) else $error("rollover without flag");
  // Oscillator ownership of the two pins
  property p_osc_oe;
    osc_run |-> !pin_a_oe && !pin_b_oe;
  endproperty
  a_osc_oe: assert property (p_osc_oe) else $error("pin driven under osc");
  property p_dir;
    rd && osc_run && addr == ADDR_PIN_DIR |=> rdata[1:0] == 2'h3;
  endproperty
  a_dir: assert property (p_dir) else $error("dir not input");
  property p_clk_ok;
    !primary_clk_ok |=> !osc_run;
  endproperty
  a_clk_ok: assert property (p_clk_ok) else $error("osc on bad clock");
  // Wake is a single pulse tied to an overflow in sleep
  property p_wake;
    wake |-> $past(sleep) && overflow_flag ##1 !wake;
  endproperty
  a_wake: assert property (p_wake) else $error("stray wake");
  c_wake: cover property (wake);
  c_dir: cover property (rd && osc_run && addr == ADDR_PIN_DIR);
  c_ovf: cover property (count_value == 16'hffff ##1 count_value == 16'h0000);
endmodule
bind stc_timer stc_timer_checker chk_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .sleep(sleep), .primary_clk_ok(primary_clk_ok),
  .pin_a_oe(pin_a_oe), .pin_b_oe(pin_b_oe), .osc_run(osc_run),
  .count_value(count_value), .overflow_flag(overflow_flag), .wake(wake));
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import stc_pkg::*;
  logic        clk, rst, wr, rd, sleep, ok, woke;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [15:0] cnt, c0;
  logic [31:0] seed;
  wire         pa, pb, pa_oe, pa_out, pb_out, run, tbv, woke_p;
  int          num_errors, checks_done, cyc, i, p;
  stc_timer uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sleep(sleep), .primary_clk_ok(ok), .pin_a_in(pa), .pin_b_in(pb),
    .pin_a_out(pa_out), .pin_a_oe(pa_oe), .pin_b_out(pb_out), .pin_b_oe(), .osc_run(run),
    .count_value(cnt), .time_base_valid(tbv), .overflow_flag(), .wake(woke_p));
  stc_ext_src ext (.osc_run(run), .pin_a(pa), .pin_b(pb));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Clock at 10 MHz
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard and sticky record of the wake pulse
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rst) begin
      woke <= 1'b0;
    end else if (woke_p === 1'b1) begin
      woke <= 1'b1;
    end
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop;
    end
  end
  // Main sequence
  initial begin
    {rst, wr, rd, sleep, addr, wdata} = '0;
    ok = 1'b1;
    num_errors = 0;
    checks_done = 0;
    seed = 32'hf3b51b40;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc(ADDR_CTRL, 8'h00);
    rdc(ADDR_CNT_HI, 8'h00);
    rdc(ADDR_PIN_DIR, 8'h03);
    rdc(3'h6, 8'h00);
    seed = xs(seed);
    wrr(ADDR_CNT_LO, seed[7:0]);
    wrr(ADDR_CNT_HI, seed[15:8]);
    rdc(ADDR_CNT_LO, seed[7:0]);
    rdc(ADDR_CNT_HI, seed[15:8]);
    // Internal clock, every prescale code, windows of six increments
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      wrr(ADDR_CNT_HI, 8'h00);
      wrr(ADDR_CNT_LO, seed[7:0]);
      wrr(ADDR_CTRL, {2'b00, 2'(i), 4'h1});
      repeat (20) @(posedge clk);
      #1 c0 = cnt;
      repeat (24 << i) @(posedge clk);
      #1 chk(cnt, c0 + 16'h0006);
    end
    wrr(ADDR_CTRL, 8'h01);
    wrr(ADDR_CNT_HI, 8'hff);
    wrr(ADDR_CNT_LO, 8'hfe);
    repeat (20) @(posedge clk);
    rdc(ADDR_FLAG, 8'h01);
    wrr(ADDR_FLAG, 8'h00);
    rdc(ADDR_FLAG, 8'h00);
    // External edges, synchronized then raw; first rise after a write is lost
    for (i = 0; i < 2; i++) begin
      seed = xs(seed);
      p = int'(seed[1:0]);
      wrr(ADDR_CTRL, {2'b00, seed[1:0], 1'b0, 1'(i), 2'b11});
      wrr(ADDR_CNT_LO, 8'h00);
      wrr(ADDR_CNT_HI, 8'h00);
      ext.pulses((3 << p) + 1);
      repeat (10) @(posedge clk);
      #1 chk(cnt, 16'h0003);
    end
    // Synchronized counting freezes in sleep, raw counting wakes
    wrr(ADDR_CTRL, 8'h03);
    wrr(ADDR_CNT_LO, 8'h00);
    sleep <= 1'b1;
    ext.pulses(5);
    chk(cnt, 16'h0000);
    wrr(ADDR_CTRL, 8'h07);
    wrr(ADDR_CNT_HI, 8'hff);
    wrr(ADDR_CNT_LO, 8'hff);
    ext.pulses(3);
    repeat (10) @(posedge clk);
    sleep <= 1'b0;
    #1 chk(cnt, 16'h0001);
    chk({15'h0000, woke}, 16'h0001);
    // Oscillator takes the pins, and only on a compatible clock
    wrr(ADDR_PIN_DIR, 8'h00);
    #1 chk({15'h0000, pa_oe}, 16'h0001);
    wrr(ADDR_PIN_DATA, 8'h03);
    #1 chk({14'h0000, pb_out, pa_out}, 16'h0003);
    wrr(ADDR_CTRL, 8'h08);
    #1 chk({15'h0000, run}, 16'h0001);
    // Crystal start-up delay before the timer is turned on
    repeat (40) @(posedge clk);
    wrr(ADDR_CTRL, 8'h0b);
    #1 chk({15'h0000, tbv}, 16'h0001);
    wrr(ADDR_CTRL, 8'h0f);
    #1 chk({15'h0000, tbv}, 16'h0000);
    rdc(ADDR_PIN_DIR, 8'h03);
    rdc(ADDR_PIN_DATA, 8'h00);
    @(posedge clk);
    ok <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({15'h0000, run}, 16'h0000);
    report_and_stop;
  end
endmodule
`default_nettype wire
